/* pkg/event_counter_regs.svh */
// Register offsets, field positions, reset values and limits of the event counter
`ifndef EVENT_COUNTER_REGS_SVH
`define EVENT_COUNTER_REGS_SVH

// Byte offsets on the register bus
`define OFS_CONTROL        5'h00
`define OFS_TARGET         5'h04
`define OFS_LOAD           5'h08
`define OFS_COUNT          5'h0c
`define OFS_STATUS         5'h10

// Control field positions
`define CTRL_DIR_BIT       0
`define CTRL_EDGE_LSB      1
`define CTRL_EDGE_MSB      2
`define CTRL_RESET_EDGE    3
`define CTRL_LATCH_BIT     4

// Status field positions
`define STAT_MATCH_BIT     0
`define STAT_COUNT_ERR     1
`define STAT_RESET_ERR     2

// Count range and reset values
`define VALUE_MAX          14'd9999
`define VALUE_ZERO         14'd0
`define TARGET_RST         14'd0
`define LOAD_RST           14'd0
`define DIR_RST            1'b0
`define EDGE_RST           2'h1
`define RESET_EDGE_RST     1'b1
`define LATCH_RST          1'b0

`endif

/* pkg/event_counter_pkg.sv */
// Types shared by the event counter design
`default_nettype none

package event_counter_pkg;

    // Which transitions of the count input are counted
    typedef enum logic [1:0] {
        EDGE_BOTH = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2
    } edge_mode_t;

    // Bus slave states, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_t;

    // Whole state of the counter
    typedef struct packed {
        logic        pulse_s1;
        logic        pulse_s2;
        logic        pulse_prev;
        logic        perr_s1;
        logic        perr_s2;
        logic        rst_s1;
        logic        rst_s2;
        logic        rst_prev;
        logic        rerr_s1;
        logic        rerr_s2;
        logic        dir_down;
        edge_mode_t  edge_mode;
        logic        reset_rise;
        logic        latch;
        logic [13:0] target;
        logic [13:0] load;
        logic [13:0] count;
        logic        match;
        logic        err;
        bus_state_t  bus;
        logic        waitreq;
        logic [31:0] rdata;
    } state_t;

endpackage

`default_nettype wire

/* core/event_counter.sv */
// Edge-counting up/down counter with target match and Avalon-MM registers
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "event_counter_regs.svh"

module event_counter
    import event_counter_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // Avalon-MM slave
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // Function block inputs
    input  wire logic        count_pulse_in,
    input  wire logic        count_err_in,
    input  wire logic        reset_pulse_in,
    input  wire logic        reset_err_in,
    // Function block outputs
    output logic             match_out,
    output logic      [13:0] count_value,
    output logic             err_out
);

    // Power-up state
    localparam state_t RESET_STATE = '{
        pulse_s1: 1'b0, pulse_s2: 1'b0, pulse_prev: 1'b0,
        perr_s1: 1'b0, perr_s2: 1'b0,
        rst_s1: 1'b0, rst_s2: 1'b0, rst_prev: 1'b0,
        rerr_s1: 1'b0, rerr_s2: 1'b0,
        dir_down: `DIR_RST,
        edge_mode: edge_mode_t'(`EDGE_RST),
        reset_rise: `RESET_EDGE_RST,
        latch: `LATCH_RST,
        target: `TARGET_RST,
        load: `LOAD_RST,
        count: `LOAD_RST,
        match: 1'b0,
        err: 1'b0,
        bus: BUS_IDLE,
        waitreq: 1'b1,
        rdata: 32'h0
    };

    state_t q;
    state_t d;
    logic   count_hit;
    logic   reset_hit;

    // Edge test against the previous sample
    function automatic logic edge_seen(input logic prev, input logic cur,
                                       input logic rise_ok, input logic fall_ok);
        edge_seen = (rise_ok && !prev && cur) || (fall_ok && prev && !cur);
    endfunction

    // One step of the count with wrap at both ends
    function automatic logic [13:0] step(input logic [13:0] v, input logic down);
        if (down)
        begin
            step = (v == `VALUE_ZERO) ? `VALUE_MAX : 14'(v - 14'd1);
        end
        else
        begin
            step = (v >= `VALUE_MAX) ? `VALUE_ZERO : 14'(v + 14'd1);
        end
    endfunction

    // Qualified edges of the two inputs, each gated by its own error only
    always_comb
    begin
        case (q.edge_mode)
            EDGE_RISE: count_hit = edge_seen(q.pulse_prev, q.pulse_s2, 1'b1, 1'b0);
            EDGE_FALL: count_hit = edge_seen(q.pulse_prev, q.pulse_s2, 1'b0, 1'b1);
            default:   count_hit = edge_seen(q.pulse_prev, q.pulse_s2, 1'b1, 1'b1);
        endcase
        count_hit = count_hit && !q.perr_s2;
        reset_hit = !q.rerr_s2
                    && edge_seen(q.rst_prev, q.rst_s2, q.reset_rise, !q.reset_rise);
    end

    // Next state
    always_comb
    begin
        d = q;
        // Input synchronisers and previous samples
        d.pulse_s1   = count_pulse_in;
        d.pulse_s2   = q.pulse_s1;
        d.pulse_prev = q.pulse_s2;
        d.perr_s1    = count_err_in;
        d.perr_s2    = q.perr_s1;
        d.rst_s1     = reset_pulse_in;
        d.rst_s2     = q.rst_s1;
        d.rst_prev   = q.rst_s2;
        d.rerr_s1    = reset_err_in;
        d.rerr_s2    = q.rerr_s1;
        d.err        = 1'b0;

        // Count: reset first, then stepping
        if (reset_hit)
        begin
            d.count = q.load;
        end
        else if (count_hit)
        begin
            d.count = step(q.count, q.dir_down);
        end

        // Match from the count/target comparison, cleared by a reset edge and held while latch is set
        if (reset_hit)
        begin
            d.match = 1'b0;
        end
        else if (q.latch)
        begin
            d.match = q.match || (q.count == q.target);
        end
        else
        begin
            d.match = (q.count == q.target);
        end

        // Bus slave: one wait cycle, then answer
        case (q.bus)
            BUS_IDLE:
            begin
                d.waitreq = 1'b1;
                if (read || write)
                begin
                    d.bus     = BUS_ACK;
                    d.waitreq = 1'b0;
                    d.rdata   = 32'h0;
                    if (read)
                    begin
                        case (address)
                            `OFS_CONTROL:
                            begin
                                d.rdata[`CTRL_DIR_BIT]                  = q.dir_down;
                                d.rdata[`CTRL_EDGE_MSB:`CTRL_EDGE_LSB]  = q.edge_mode;
                                d.rdata[`CTRL_RESET_EDGE]               = q.reset_rise;
                                d.rdata[`CTRL_LATCH_BIT]                = q.latch;
                            end
                            `OFS_TARGET: d.rdata[13:0] = q.target;
                            `OFS_LOAD:   d.rdata[13:0] = q.load;
                            `OFS_COUNT:  d.rdata[13:0] = q.count;
                            `OFS_STATUS:
                            begin
                                d.rdata[`STAT_MATCH_BIT] = q.match;
                                d.rdata[`STAT_COUNT_ERR] = q.perr_s2;
                                d.rdata[`STAT_RESET_ERR] = q.rerr_s2;
                            end
                            default:     d.rdata = 32'h0;
                        endcase
                    end
                end
            end
            BUS_ACK:
            begin
                d.bus     = BUS_IDLE;
                d.waitreq = 1'b1;
                if (write)
                begin
                    case (address)
                        `OFS_CONTROL:
                        begin
                            d.dir_down   = writedata[`CTRL_DIR_BIT];
                            d.edge_mode  = edge_mode_t'(writedata[`CTRL_EDGE_MSB:`CTRL_EDGE_LSB]);
                            d.reset_rise = writedata[`CTRL_RESET_EDGE];
                            d.latch      = writedata[`CTRL_LATCH_BIT];
                        end
                        `OFS_TARGET:
                        begin
                            // Out-of-range values are ignored
                            if (writedata[31:14] == 18'h0 && writedata[13:0] <= `VALUE_MAX)
                            begin
                                d.target = writedata[13:0];
                            end
                        end
                        `OFS_LOAD:
                        begin
                            if (writedata[31:14] == 18'h0 && writedata[13:0] <= `VALUE_MAX)
                            begin
                                d.load = writedata[13:0];
                            end
                        end
                        default:
                        begin
                            // Read-only and unmapped places keep their data
                            d.rdata = q.rdata;
                        end
                    endcase
                end
            end
            default:
            begin
                d.bus     = BUS_IDLE;
                d.waitreq = 1'b1;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= RESET_STATE;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign readdata    = q.rdata;
    assign waitrequest = q.waitreq;
    assign match_out   = q.match;
    assign count_value = q.count;
    assign err_out     = q.err;

    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence s_bus_req;
        (q.bus == BUS_IDLE) && (read || write);
    endsequence

    sequence s_bus_answer;
        !waitrequest ##1 waitrequest;
    endsequence

    a_bus_one_wait: assert property (s_bus_req |=> s_bus_answer)
        else $error("bus answer not one cycle wide");

    // No answer without a request
    a_bus_idle_wait: assert property ((q.bus == BUS_IDLE) && !read && !write |=> waitrequest)
        else $error("bus answered without a request");

    a_up_step: assert property (count_hit && !reset_hit && !q.dir_down && q.count < `VALUE_MAX
        |=> q.count == $past(q.count) + 14'd1)
        else $error("up count did not add one");

    a_down_step: assert property (count_hit && !reset_hit && q.dir_down && q.count != 14'd0
        |=> q.count == $past(q.count) - 14'd1)
        else $error("down count did not subtract one");

    a_match_equal: assert property (!reset_hit && q.count == q.target |=> match_out)
        else $error("match missing on equal count");

    a_reset_load: assert property (reset_hit |=> count_value == $past(q.load) && !match_out)
        else $error("reset did not reload or clear match");

    a_latch_hold: assert property (q.latch && q.match && !reset_hit |=> match_out)
        else $error("latched match dropped without reset");

    a_nolatch_drop: assert property (!q.latch && q.count != q.target |=> !match_out)
        else $error("unlatched match on unequal count");

    a_both_edges: assert property (q.edge_mode == EDGE_BOTH && q.pulse_prev != q.pulse_s2
        && !q.perr_s2 && !reset_hit |=> $changed(count_value))
        else $error("both-edge count missed a transition");

    a_rise_only: assert property (q.edge_mode == EDGE_RISE && q.pulse_prev && !q.pulse_s2
        && !reset_hit |=> $stable(count_value))
        else $error("falling edge counted in rise mode");

    a_rise_count: assert property (q.edge_mode == EDGE_RISE && !q.pulse_prev && q.pulse_s2
        && !q.perr_s2 && !reset_hit |=> $changed(count_value))
        else $error("rising edge missed in rise mode");

    a_fall_only: assert property (q.edge_mode == EDGE_FALL && !q.pulse_prev && q.pulse_s2
        && !reset_hit |=> $stable(count_value))
        else $error("rising edge counted in fall mode");

    a_fall_count: assert property (q.edge_mode == EDGE_FALL && q.pulse_prev && !q.pulse_s2
        && !q.perr_s2 && !reset_hit |=> $changed(count_value))
        else $error("falling edge missed in fall mode");

    a_reset_polarity: assert property (!q.rerr_s2 && q.rst_prev != q.rst_s2
        && q.rst_s2 == q.reset_rise && !count_hit |=> count_value == $past(q.load))
        else $error("selected reset edge ignored");

    a_count_range: assert property (count_value <= `VALUE_MAX)
        else $error("count outside range");

    a_up_wrap: assert property (count_hit && !reset_hit && !q.dir_down && q.count == `VALUE_MAX
        |=> count_value == 14'd0)
        else $error("up count did not wrap to zero");

    a_count_err: assert property (q.perr_s2 && !reset_hit |=> $stable(count_value))
        else $error("count moved despite count error");

    a_reset_err: assert property (q.rerr_s2 && !count_hit |=> $stable(count_value))
        else $error("reset acted despite reset error");

    a_err_isolate: assert property (q.rerr_s2 && count_hit && !q.dir_down && q.count < `VALUE_MAX
        |=> count_value == $past(q.count) + 14'd1)
        else $error("reset error blocked counting");

    a_reset_isolate: assert property (q.perr_s2 && reset_hit
        |=> count_value == $past(q.load))
        else $error("count error blocked reset");

    a_no_error: assert property (!err_out)
        else $error("error output raised");

    a_down_wrap: assert property (count_hit && !reset_hit && q.dir_down && q.count == 14'd0
        |=> count_value == `VALUE_MAX)
        else $error("down count did not wrap to top");

    a_reset_priority: assert property (reset_hit && count_hit |=> count_value == $past(q.load))
        else $error("count beat reset in same cycle");

endmodule

`default_nettype wire

/* tb/event_source.sv */
// Behavioural model of the function blocks that drive the counter inputs
`timescale 1ns/10ps
`default_nettype none

module event_source
(
    // Clock
    input  wire logic mclk,
    // Count and reset lines with their error flags
    output logic      count_pulse_in,
    output logic      count_err_in,
    output logic      reset_pulse_in,
    output logic      reset_err_in
);

    // Idle levels from time zero
    initial
    begin
        count_pulse_in = 1'b0;
        count_err_in   = 1'b0;
        reset_pulse_in = 1'b0;
        reset_err_in   = 1'b0;
    end

    // Flip chosen lines, hold until count and match have settled
    task automatic toggle(input logic c, input logic r);
        if (c)
            count_pulse_in <= ~count_pulse_in;
        if (r)
            reset_pulse_in <= ~reset_pulse_in;
        repeat (6) @(posedge mclk);
    endtask

    // Set error flags, hold until synchronised
    task automatic set_err(input logic c, input logic r);
        count_err_in <= c;
        reset_err_in <= r;
        repeat (4) @(posedge mclk);
    endtask

endmodule

`default_nettype wire

/* tb/testbench.sv */
// Self-checking testbench of the event counter
`timescale 1ns/10ps
`default_nettype none
`include "event_counter_regs.svh"

module testbench;

    // Case table entry
    typedef struct packed {
        logic [4:0]  ctrl;
        logic [13:0] load;
        logic [13:0] target;
        logic [3:0]  n;
        logic [13:0] cnt;
        logic        m;
    } row_t;

    logic        mclk;
    logic        rstn;
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        count_pulse_in;
    logic        count_err_in;
    logic        reset_pulse_in;
    logic        reset_err_in;
    logic        match_out;
    logic [13:0] count_value;
    logic        err_out;
    logic [31:0] q;
    int          n_fail = 0;
    int          n_checks = 0;

    // Ordinary cases; all use the rising reset edge
    row_t rows [6] = '{
        '{5'h08, 14'h0005, 14'h0009, 4'h4, 14'h0009, 1'b1},
        '{5'h0a, 14'h270e, 14'h0000, 4'h4, 14'h0000, 1'b1},
        '{5'h0d, 14'h0001, 14'h270f, 4'h4, 14'h270f, 1'b1},
        '{5'h09, 14'h0003, 14'h0002, 4'h2, 14'h0001, 1'b0},
        '{5'h0e, 14'h0000, 14'h0000, 4'h2, 14'h0002, 1'b0},
        '{5'h18, 14'h0003, 14'h0004, 4'h2, 14'h0005, 1'b1}
    };

    event_counter event_counter_i (
        .mclk           (mclk),
        .rstn           (rstn),
        .address        (address),
        .read           (read),
        .write          (write),
        .writedata      (writedata),
        .readdata       (readdata),
        .waitrequest    (waitrequest),
        .count_pulse_in (count_pulse_in),
        .count_err_in   (count_err_in),
        .reset_pulse_in (reset_pulse_in),
        .reset_err_in   (reset_err_in),
        .match_out      (match_out),
        .count_value    (count_value),
        .err_out        (err_out)
    );

    event_source event_source_i (
        .mclk           (mclk),
        .count_pulse_in (count_pulse_in),
        .count_err_in   (count_err_in),
        .reset_pulse_in (reset_pulse_in),
        .reset_err_in   (reset_err_in)
    );

    // Clock, 100 ns period
    always #50 mclk = ~mclk;

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One Avalon access, read data left in q
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        read <= ~wr;
        write <= wr;
        do
        begin
            @(posedge mclk);
        end
        while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
    endtask

    // Verdict and end of run
    task automatic summarize();
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Reset values of all places, one unmapped
    task automatic check_regs();
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b0, 5'(i * 4), 32'h0);
            check(q, (i == 0) ? 32'h0000000a : (i == 4) ? 32'h00000001 : 32'h0);
        end
    endtask

    // Main sequence
    initial
    begin
        mclk = 1'b0;
        rstn = 1'b0;
        address = 5'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        check(count_value, 32'h0);
        check({match_out, err_out, waitrequest}, 32'h1);
        check_regs();
        foreach (rows[i])
        begin
            bus(1'b1, `OFS_CONTROL, {27'h0, rows[i].ctrl});
            bus(1'b1, `OFS_LOAD, {18'h0, rows[i].load});
            bus(1'b1, `OFS_TARGET, {18'h0, rows[i].target});
            event_source_i.toggle(1'b0, 1'b1);
            check(count_value, rows[i].load);
            event_source_i.toggle(1'b0, 1'b1);
            repeat (rows[i].n) event_source_i.toggle(1'b1, 1'b0);
            check(count_value, rows[i].cnt);
            check(match_out, rows[i].m);
            bus(1'b0, `OFS_COUNT, 32'h0);
            check(q, {18'h0, rows[i].cnt});
            bus(1'b0, `OFS_STATUS, 32'h0);
            check(q, {31'h0, rows[i].m});
        end
        // Reset line in error: reset ignored, counting goes on
        event_source_i.set_err(1'b0, 1'b1);
        event_source_i.toggle(1'b0, 1'b1);
        check(count_value, 32'h5);
        event_source_i.toggle(1'b1, 1'b0);
        check(count_value, 32'h6);
        check(match_out, 1'b1);
        bus(1'b0, `OFS_STATUS, 32'h0);
        check(q, 32'h00000005);
        event_source_i.toggle(1'b0, 1'b1);
        // Count line in error: counting stops, reset still works
        event_source_i.set_err(1'b1, 1'b0);
        event_source_i.toggle(1'b1, 1'b0);
        check(count_value, 32'h6);
        bus(1'b0, `OFS_STATUS, 32'h0);
        check(q, 32'h00000003);
        check(err_out, 1'b0);
        event_source_i.toggle(1'b0, 1'b1);
        check(count_value, 32'h3);
        check(match_out, 1'b0);
        event_source_i.toggle(1'b0, 1'b1);
        event_source_i.set_err(1'b0, 1'b0);
        // Falling reset edge selected
        bus(1'b1, `OFS_CONTROL, 32'h00000010);
        repeat (2) event_source_i.toggle(1'b1, 1'b0);
        event_source_i.toggle(1'b0, 1'b1);
        check(count_value, 32'h5);
        event_source_i.toggle(1'b0, 1'b1);
        check(count_value, 32'h3);
        // Reset and count edge in one cycle
        bus(1'b1, `OFS_CONTROL, 32'h00000008);
        event_source_i.toggle(1'b1, 1'b1);
        check(count_value, 32'h3);
        event_source_i.toggle(1'b1, 1'b1);
        check(count_value, 32'h4);
        // Refused writes
        bus(1'b1, `OFS_TARGET, 32'h00002710);
        bus(1'b1, `OFS_COUNT, 32'h00000007);
        bus(1'b1, 5'h14, 32'h00000001);
        bus(1'b0, `OFS_TARGET, 32'h0);
        check(q, 32'h00000004);
        check(count_value, 32'h4);
        // Second reset in mid-run
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        check(count_value, 32'h0);
        check_regs();
        summarize();
    end

    // Watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        summarize();
    end

endmodule

`default_nettype wire
